// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic clk_i, resetn_i, psel, penable, pwrite, brk, ext_run;
    logic [31:0] paddr, pwdata, rd;
    logic er;
    wire [31:0] prdata;
    wire pready, pslverr, p0, p0e, p1, p1e, irq, ev0, ev1, extc;
    // line level resolved from both drivers
    wire w0 = p0e ? p0 : ev0;
    wire w1 = p1e ? p1 : ev1;
    int errors, compares, cyc, seed, m, v, dv, t0, t1, t2, c, hit;
    logic [31:0] rv [8] = '{32'h20, 0, 32'hffff, 0, 0, 0, 0, 0};
    tu_timer uut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .break_i(brk), .external_timer_clock_pin_i(extc), .chan0_pin_i(w0), .chan0_pin_o(p0),
        .chan0_pin_oe_o(p0e), .chan1_pin_i(w1), .chan1_pin_o(p1), .chan1_pin_oe_o(p1e), .irq_o(irq));
    tu_pin_model pm (.clk_i(clk_i), .ext_run_i(ext_run), .ev0_o(ev0), .ev1_o(ev1), .ext_o(extc));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // hang guard, well above the longest run of the sequence
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            close_out();
        end
    end
    task close_out();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task apb(input logic w, input [31:0] a, input [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_lvl(input logic l);
        int n;
        n = 0;
        while (p0 !== l && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task pulse_width();
        wait_lvl(0);
        wait_lvl(1);
        t0 = cyc;
        wait_lvl(0);
        t1 = cyc;
        wait_lvl(1);
        t2 = cyc;
    endtask
    task steady(input logic l);
        int bad;
        bad = 0;
        repeat (25) @(posedge clk_i);
        repeat (40) begin
            @(posedge clk_i);
            if (p0 !== l) bad++;
        end
        chk(bad, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, brk, ext_run, paddr, pwdata} = '0;
        errors = 0;
        compares = 0;
        cyc = 0;
        seed = $urandom(32'h4ca3312f);
        resetn_i = 1'b0;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            apb(0, 4 * i, 0);
            chk(rd, i < 8 ? rv[i] : 0);
            chk(er, i == 8);
        end
        $display("reset values done");
        for (int ps = 0; ps < 8; ps++) begin
            m = $urandom_range(15, 2);
            v = $urandom_range(m, 1);
            dv = (ps == 7) ? 10 : (1 << ps);
            ext_run <= (ps == 7);
            apb(1, 0, 32'h30);
            apb(1, 8, m);
            apb(1, 32'h10, v);
            apb(1, 12, 32'h1a);
            apb(1, 0, ps);
            pulse_width();
            chk(t2 - t0, (m + 1) * dv);
            chk(t1 - t0, v * dv);
        end
        ext_run <= 1'b0;
        apb(1, 0, 32'h30);
        apb(1, 8, 9);
        apb(1, 32'h10, 4);
        apb(1, 12, 32'h18);
        apb(1, 0, 0);
        steady(0);
        apb(1, 12, 32'h1b);
        steady(1);
        $display("pwm rates done");
        apb(0, 4, 0);
        brk <= 1'b1;
        apb(0, 4, 0);
        c = rd;
        repeat (6) @(posedge clk_i);
        apb(0, 4, 0);
        chk(rd, c);
        for (int ls = 1; ls < 5; ls++) begin
            for (int e = 0; e < 2; e++) begin
                // code 4 is rising-edge capture with the request masked
                hit = ((ls == 4 ? 1 : ls) & (e + 1)) != 0;
                apb(1, 32'h18, 32'hffff);
                apb(1, 32'h14, ls == 4 ? 32'h84 : (32'hc0 | (ls << 2)));
                pm.drive(1, e == 0, e);
                repeat (6) @(posedge clk_i);
                apb(0, 32'h18, 0);
                chk(rd, hit ? c : 32'hffff);
                apb(0, 32'h14, 0);
                chk(rd[7], hit);
                chk(irq, ls < 4 && hit);
            end
        end
        brk <= 1'b0;
        $display("capture done");
        apb(1, 0, 32'h30);
        apb(0, 4, 0);
        chk(rd, 0);
        apb(1, 8, 20);
        apb(1, 32'h10, 5);
        apb(1, 12, 32'h3a);
        apb(1, 32'h18, 12);
        apb(0, 32'h1c, 0);
        chk(rd, 0);
        chk(p1e, 0);
        apb(1, 0, 0);
        for (int k = 0; k < 2; k++) begin
            repeat (30) @(posedge clk_i);
            apb(0, 32'h1c, 0);
            chk(rd, 1 - k);
            pulse_width();
            chk(t1 - t0, k ? 7 : 12);
            chk(t2 - t0, 21);
            apb(1, 32'h10, 7);
        end
        $display("buffered done");
        close_out();
    end
endmodule // tb_top

// ---- bench/tu_pin_model.sv ----
`timescale 1ns/1ps
module tu_pin_model (
    input wire clk_i,
    input wire ext_run_i,
    output logic ev0_o,
    output logic ev1_o,
    output logic ext_o
);
    int hc;
    initial begin
        ev0_o = 1'b0;
        ev1_o = 1'b0;
        ext_o = 1'b0;
        hc = 0;
    end
    // external clock only runs while asked, stands low between runs
    always @(posedge clk_i) begin
        if (!ext_run_i) begin
            ext_o <= 1'b0;
            hc <= 0;
        end else if (hc == 4) begin
            ext_o <= ~ext_o;
            hc <= 0;
        end else begin
            hc <= hc + 1;
        end
    end
    // event source on a channel line, prompt or slow
    task drive(input int ch, input logic lvl, input int slow);
        repeat (slow ? 7 : 1) @(posedge clk_i);
        if (ch == 0) ev0_o <= lvl;
        else ev1_o <= lvl;
    endtask
endmodule // tu_pin_model

// ---- bench/tu_timer_props.sv ----
`timescale 1ns/1ps
module tu_timer_props (
    input wire clk_i,
    input wire resetn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [31:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire break_i,
    input wire external_timer_clock_pin_i,
    input wire chan0_pin_i,
    input wire chan0_pin_o,
    input wire chan0_pin_oe_o,
    input wire chan1_pin_i,
    input wire chan1_pin_o,
    input wire chan1_pin_oe_o,
    input wire irq_o
);
    // mirror of the written mode bits, so pin enables can be predicted
    reg [6:2] cs0;
    reg [6:2] cs1;
    reg oie;
    wire wr = psel_i & penable_i & pwrite_i;
    wire cmp0 = cs0[5] | cs0[4];
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs0 <= 5'h00;
            cs1 <= 5'h00;
            oie <= 1'b0;
        end else if (wr) begin
            if (paddr_i == 32'h0c) cs0 <= pwdata_i[6:2];
            if (paddr_i == 32'h14) cs1 <= pwdata_i[6:2];
            if (paddr_i == 32'h00) oie <= pwdata_i[6];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_oe0_mode:
        assert property (chan0_pin_oe_o == (cmp0 && cs0[3:2] != 2'b00)) else $error("ch0 enable wrong");
    a_oe1_mode:
        assert property (!cs0[5] |-> chan1_pin_oe_o == (cs1[4] && cs1[3:2] != 2'b00)) else $error("ch1 enable wrong");
    a_link_release:
        assert property (cs0[5] |-> !chan1_pin_oe_o) else $error("ch1 driven while linked");
    a_pin0_idle:
        assert property (!cmp0 && !$past(cmp0) |-> !chan0_pin_o) else $error("ch0 pin high outside compare");
    a_pin1_idle:
        assert property (!cs1[4] && !$past(cs1[4]) |-> !chan1_pin_o) else $error("ch1 pin high outside compare");
    a_irq_gate:
        assert property (!(oie | cs0[6] | cs1[6]) |-> !irq_o) else $error("irq without enable");
    a_irq_hold:
        assert property ($fell(irq_o) |-> $past(wr)) else $error("irq dropped without write");
    a_break_freeze:
        assert property ($past(break_i) && !$past(wr) |-> $stable(chan0_pin_o) && $stable(chan1_pin_o))
            else $error("pin moved during break");
    a_count_width:
        assert property (psel_i && penable_i && !pwrite_i && paddr_i == 32'h04 |-> prdata_o[31:16] == 16'h0000
            && !pslverr_o) else $error("count read wrong width");
    c_irq: cover property (irq_o && cs1[6]);
    c_link: cover property (cs0[5] && chan0_pin_oe_o);
    c_brk: cover property (break_i && chan0_pin_o);
endmodule // tu_timer_props
bind tu_timer tu_timer_props chk (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .break_i(break_i), .external_timer_clock_pin_i(external_timer_clock_pin_i),
    .chan0_pin_i(chan0_pin_i), .chan0_pin_o(chan0_pin_o), .chan0_pin_oe_o(chan0_pin_oe_o),
    .chan1_pin_i(chan1_pin_i), .chan1_pin_o(chan1_pin_o), .chan1_pin_oe_o(chan1_pin_oe_o), .irq_o(irq_o));

// ---- rtl/tu_consts.vh ----
`ifndef TU_CONSTS_VH
`define TU_CONSTS_VH
// register byte addresses
`define TU_OFF_CTRL 5'h00
`define TU_OFF_COUNT 5'h04
`define TU_OFF_MOD 5'h08
`define TU_OFF_C0CS 5'h0c
`define TU_OFF_C0VAL 5'h10
`define TU_OFF_C1CS 5'h14
`define TU_OFF_C1VAL 5'h18
`define TU_OFF_LINK 5'h1c
// timer_ctrl_status fields
`define TU_CTRL_OVF 7
`define TU_CTRL_OIE 6
`define TU_CTRL_STOP 5
`define TU_CTRL_RST 4
`define TU_CTRL_PS_HI 2
`define TU_CTRL_PS_LO 0
// channel ctrl/status fields
`define TU_CS_FLAG 7
`define TU_CS_IE 6
`define TU_CS_MSB 5
`define TU_CS_MSA 4
`define TU_CS_ELS_HI 3
`define TU_CS_ELS_LO 2
`define TU_CS_TOV 1
`define TU_CS_MAX 0
// reset values
`define TU_RST_CTRL 8'h20
`define TU_RST_MOD 16'hffff
`define TU_RST_CS 8'h00
`define TU_RST_VAL 16'h0000
// prescaler select code that picks the external clock pin
`define TU_PS_EXT 3'h7
`endif

// ---- rtl/tu_prescaler.v ----
`timescale 1ns/1ps
`include "tu_consts.vh"
module tu_prescaler (
    input wire clk_i,
    input wire resetn_i,
    input wire clear_i,
    input wire run_i,
    input wire [2:0] sel_i,
    input wire ext_clk_i,
    output wire tick_o
);
    reg [5:0] div;
    reg ext_s1;
    reg ext_s2;
    reg ext_prev;
    wire [6:0] div_next;
    wire int_tick;

    ////////////////////////////////////////////////////////////////////////////////
    // two flip-flops before the pin is looked at
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_s1 <= ext_clk_i;
            ext_s2 <= ext_s1;
            ext_prev <= ext_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // R5 divider chain
    assign div_next = {1'b0, div} + 7'h01;
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div <= 6'h00;
        end else if (clear_i) begin
            div <= 6'h00;
        end else if (run_i) begin
            div <= div_next[5:0];
        end
    end

    // rate 2^sel: tick when the low sel bits of the divider are all ones
    assign int_tick = ((div | (6'h3f << sel_i)) == 6'h3f);
    // R5 source select
    // R19 code 000 ticks every bus clock
    assign tick_o = run_i & ((sel_i == `TU_PS_EXT) ? (ext_s2 & ~ext_prev) : int_tick);
endmodule // tu_prescaler

// ---- rtl/tu_timer.v ----
// Overview of operation
// R1 - sixteen-bit up-counter, free-running or modulo, is the time base
// R2 - in modulo mode the modulo pair is the terminal count
// R3 - counter readable any time without disturbing the count
// R4 - each of two channels is capture or compare on its own
// R5 - counter clocked from seven bus-clock rates or external pin by select field
// R6 - active capture edge (rising, falling, either) copies counter into value pair
// R7 - capture event can raise an interrupt request
// R8 - compare match sets, clears or toggles the channel pin
// R9 - compare match can raise an interrupt request
// R10 - unbuffered compare value takes effect at once, no shadow
// R11 - software lowers unbuffered value from compare interrupt handler
// R12 - software raises unbuffered value from overflow interrupt handler
// R13 - link bit joins channels 0 and 1, output on channel-0 pin
// R14 - buffered pair starts with channel 0; overflow hands control to last written
// R15 - linked pair run by channel-0 control; channel-1 control ignored, pin released
// R16 - software writes only the inactive channel in buffered mode
// R17 - toggle-on-overflow toggles pin at modulo value, forming PWM period
// R18 - pulse width is overflow to match; clear for high, set for low pulse
// R19 - select 000 counts every bus clock; modulo N gives N+1 periods
// R20 - 8-bit PWM period and width adjust in 256 steps
// R21 - stop bit, counter/prescaler reset bit, toggle any pin on overflow
// R22 - overflow flag set at modulo value, interrupt when enabled
// R23 - channel flag set on each capture or compare, interrupt when enabled
// R24 - no overflow toggle gives 0% duty; full-duty with toggle gives 100%
// R25 - counter halts while break is active
// R26 - tick after modulo value reloads counter to zero
`timescale 1ns/1ps
`include "tu_consts.vh"
module tu_timer (
    input wire clk_i,
    input wire resetn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [31:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire break_i,
    input wire external_timer_clock_pin_i,
    input wire chan0_pin_i,
    output reg chan0_pin_o,
    output wire chan0_pin_oe_o,
    input wire chan1_pin_i,
    output reg chan1_pin_o,
    output wire chan1_pin_oe_o,
    output wire irq_o
);
    reg [7:0] timer_ctrl_status;
    reg [15:0] count;
    reg [15:0] counter_modulo_pair;
    reg [7:0] chan_cs [0:1];
    reg [15:0] channel_value_pair [0:1];
    reg active_chan;
    reg last_written;
    reg [1:0] pin_s1;
    reg [1:0] pin_s2;
    reg [1:0] pin_prev;
    wire tick;
    wire wr_en;
    wire rd_en;
    wire [4:0] addr;
    wire mapped;
    wire ctr_rst;
    wire run;
    wire wrap;
    wire [15:0] next_count;
    wire [16:0] count_inc;
    wire linked;
    reg [1:0] cap_hit;
    reg [1:0] cmp_hit;
    reg [1:0] is_cmp;
    reg [1:0] next_pin;
    integer i;
    integer j;
    integer n;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function edge_hit;
        input prev;
        input cur;
        input [1:0] els;
        begin
            edge_hit = (els[0] & ~prev & cur) | (els[1] & prev & ~cur);
        end
    endfunction

    function cmp_action;
        input cur;
        input [1:0] els;
        begin
            case (els)
                2'b01: cmp_action = ~cur;
                2'b10: cmp_action = 1'b0;
                2'b11: cmp_action = 1'b1;
                default: cmp_action = cur;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, unmapped address answers with an error
    assign addr = paddr_i[4:0];
    assign mapped = (paddr_i[31:5] == 27'h0000000) && (addr[1:0] == 2'b00);
    assign wr_en = psel_i & penable_i & pwrite_i & mapped;
    assign rd_en = psel_i & penable_i & ~pwrite_i;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    // R3 read path only samples state
    always @* begin
        prdata_o = 32'h00000000;
        case (addr)
            `TU_OFF_CTRL: prdata_o = {24'h000000, timer_ctrl_status};
            `TU_OFF_COUNT: prdata_o = {16'h0000, count};
            `TU_OFF_MOD: prdata_o = {16'h0000, counter_modulo_pair};
            `TU_OFF_C0CS: prdata_o = {24'h000000, chan_cs[0]};
            `TU_OFF_C0VAL: prdata_o = {16'h0000, channel_value_pair[0]};
            `TU_OFF_C1CS: prdata_o = {24'h000000, chan_cs[1]};
            `TU_OFF_C1VAL: prdata_o = {16'h0000, channel_value_pair[1]};
            `TU_OFF_LINK: prdata_o = {31'h00000000, active_chan};
            default: prdata_o = 32'h00000000;
        endcase
        if (!rd_en || !mapped) begin
            prdata_o = 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counter clocking
    // R21 reset bit is a write-one pulse that clears counter and prescaler
    assign ctr_rst = wr_en && (addr == `TU_OFF_CTRL) && pwdata_i[`TU_CTRL_RST];
    // R21 stop bit
    // R25 break halts counting
    assign run = ~timer_ctrl_status[`TU_CTRL_STOP] & ~break_i;

    tu_prescaler u_presc (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .clear_i(ctr_rst),
        .run_i(run),
        .sel_i(timer_ctrl_status[`TU_CTRL_PS_HI:`TU_CTRL_PS_LO]),
        .ext_clk_i(external_timer_clock_pin_i),
        .tick_o(tick)
    );

    // R2 modulo value is the terminal count
    // R26 wrap to zero on the tick after reaching it
    assign wrap = tick && (count == counter_modulo_pair);
    assign count_inc = {1'b0, count} + 17'h00001;
    assign next_count = wrap ? 16'h0000 : count_inc[15:0];

    // R1 up-counter, free-running while modulo is all ones
    // R19 one count per tick, N+1 ticks per period
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count <= 16'h0000;
        end else if (ctr_rst) begin
            count <= 16'h0000;
        end else if (tick) begin
            count <= next_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // timer control/status and modulo
    // R22 overflow flag; set beats a same-cycle clear
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer_ctrl_status <= `TU_RST_CTRL;
            counter_modulo_pair <= `TU_RST_MOD;
        end else begin
            if (wr_en && addr == `TU_OFF_CTRL) begin
                timer_ctrl_status[`TU_CTRL_OIE] <= pwdata_i[`TU_CTRL_OIE];
                timer_ctrl_status[`TU_CTRL_STOP] <= pwdata_i[`TU_CTRL_STOP];
                timer_ctrl_status[`TU_CTRL_PS_HI:`TU_CTRL_PS_LO] <= pwdata_i[`TU_CTRL_PS_HI:`TU_CTRL_PS_LO];
                if (pwdata_i[`TU_CTRL_OVF]) begin
                    timer_ctrl_status[`TU_CTRL_OVF] <= 1'b0;
                end
            end
            if (wrap) begin
                timer_ctrl_status[`TU_CTRL_OVF] <= 1'b1;
            end
            timer_ctrl_status[`TU_CTRL_RST] <= 1'b0;
            timer_ctrl_status[3] <= 1'b0;
            if (wr_en && addr == `TU_OFF_MOD) begin
                counter_modulo_pair <= pwdata_i[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // channel pin synchronisers
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_s1 <= 2'b00;
            pin_s2 <= 2'b00;
            pin_prev <= 2'b00;
        end else begin
            pin_s1 <= {chan1_pin_i, chan0_pin_i};
            pin_s2 <= pin_s1;
            pin_prev <= pin_s2;
        end
    end

    // R13 pair link bit on channel 0
    assign linked = chan_cs[0][`TU_CS_MSB];

    ////////////////////////////////////////////////////////////////////////////////
    // channel event detection
    always @* begin
        for (j = 0; j < 2; j = j + 1) begin
            // R4 mode per channel: any mode bit set means compare
            is_cmp[j] = chan_cs[j][`TU_CS_MSA] | chan_cs[j][`TU_CS_MSB];
            // R6 programmable capture edge
            cap_hit[j] = ~is_cmp[j] & edge_hit(pin_prev[j], pin_s2[j], chan_cs[j][`TU_CS_ELS_HI:`TU_CS_ELS_LO]);
            // R8 match against the live value pair
            // R10 no shadow, a new value counts at once
            // R20 full-width compare, so 8-bit widths step by one
            cmp_hit[j] = is_cmp[j] & tick & (next_count == channel_value_pair[j]);
        end
        // R14 linked pair compares the active channel's value
        if (linked) begin
            is_cmp[0] = 1'b1;
            cap_hit[0] = 1'b0;
            cmp_hit[0] = tick & (next_count == channel_value_pair[active_chan]);
        end
        // R15 channel-1 control is ignored while linked
        if (linked) begin
            is_cmp[1] = 1'b0;
            cap_hit[1] = 1'b0;
            cmp_hit[1] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin output levels
    always @* begin
        for (n = 0; n < 2; n = n + 1) begin
            next_pin[n] = (n == 0) ? chan0_pin_o : chan1_pin_o;
            // R17 toggle at the modulo value forms the period
            // R21 any compare-mode channel may toggle on overflow
            // R24 without the toggle bit clear-on-match compares never leave the idle level
            if (wrap && chan_cs[n][`TU_CS_TOV]) begin
                next_pin[n] = ~next_pin[n];
            end
            // R18 clear or set on match ends the pulse
            if (cmp_hit[n]) begin
                next_pin[n] = cmp_action(next_pin[n], chan_cs[n][`TU_CS_ELS_HI:`TU_CS_ELS_LO]);
            end
            // R24 full duty holds the pulse level
            if (chan_cs[n][`TU_CS_MAX] && chan_cs[n][`TU_CS_TOV]) begin
                next_pin[n] = ~chan_cs[n][`TU_CS_ELS_LO];
            end
            if (!is_cmp[n]) begin
                next_pin[n] = 1'b0;
            end
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            chan0_pin_o <= 1'b0;
            chan1_pin_o <= 1'b0;
        end else begin
            chan0_pin_o <= next_pin[0];
            chan1_pin_o <= next_pin[1];
        end
    end

    // pin driven only in compare mode with an action selected
    // R13 linked output leaves on the channel-0 pin
    assign chan0_pin_oe_o = is_cmp[0] & (chan_cs[0][`TU_CS_ELS_HI:`TU_CS_ELS_LO] != 2'b00);
    // R15 channel-1 pin released for general use
    assign chan1_pin_oe_o = is_cmp[1] & (chan_cs[1][`TU_CS_ELS_HI:`TU_CS_ELS_LO] != 2'b00);

    ////////////////////////////////////////////////////////////////////////////////
    // channel registers
    // the pair link bit exists only on channel 0; channel 1 reads it as zero
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            chan_cs[0] <= `TU_RST_CS;
            chan_cs[1] <= `TU_RST_CS;
            channel_value_pair[0] <= `TU_RST_VAL;
            channel_value_pair[1] <= `TU_RST_VAL;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                if (wr_en && addr == ((i == 0) ? `TU_OFF_C0CS : `TU_OFF_C1CS)) begin
                    chan_cs[i][6:0] <= pwdata_i[6:0];
                    if (i == 1) begin
                        chan_cs[i][`TU_CS_MSB] <= 1'b0;
                    end
                    if (pwdata_i[`TU_CS_FLAG]) begin
                        chan_cs[i][`TU_CS_FLAG] <= 1'b0;
                    end
                end
                if (wr_en && addr == ((i == 0) ? `TU_OFF_C0VAL : `TU_OFF_C1VAL)) begin
                    channel_value_pair[i] <= pwdata_i[15:0];
                end
                // R6 capture wins over a same-cycle software write
                if (cap_hit[i]) begin
                    channel_value_pair[i] <= count;
                end
                // R23 flag on every capture or compare; set beats clear
                // R7 capture event flagged
                // R9 compare event flagged
                if (cap_hit[i] || cmp_hit[i]) begin
                    chan_cs[i][`TU_CS_FLAG] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // buffered pair bookkeeping
    // R14 start on channel 0, hand over at overflow to the last written
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            active_chan <= 1'b0;
            last_written <= 1'b0;
        end else if (!linked) begin
            active_chan <= 1'b0;
            last_written <= 1'b0;
        end else begin
            if (wr_en && addr == `TU_OFF_C0VAL) begin
                last_written <= 1'b0;
            end
            if (wr_en && addr == `TU_OFF_C1VAL) begin
                last_written <= 1'b1;
            end
            if (wrap) begin
                active_chan <= last_written;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request line; level, follows flags and enables
    // R22 overflow request gated by its enable
    // R23 channel requests gated by their enables
    assign irq_o = (timer_ctrl_status[`TU_CTRL_OVF] & timer_ctrl_status[`TU_CTRL_OIE])
        | (chan_cs[0][`TU_CS_FLAG] & chan_cs[0][`TU_CS_IE])
        | (chan_cs[1][`TU_CS_FLAG] & chan_cs[1][`TU_CS_IE]);
endmodule // tu_timer
